// [core/sleep_measurement_sequencer.v]
// power manager sequencer for light and deep sleep with discrete measurements
`timescale 1ns/10ps
`include "sleep_seq_consts.vh"
module sleep_measurement_sequencer (
   // clock, reset, enable
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_clk_en,
   // serial register port
   input wire i_powerdown_command_wr,
   input wire [`CMD_W-1:0] i_powerdown_command,
   input wire i_chip_select_n,
   // low power configuration
   input wire [`PD_STATE_W-1:0] i_powerdown_state_select,
   input wire [`MEAS_W-1:0] i_powerdown_measure_select,
   input wire i_sleep_bias_reduce_ten,
   input wire i_sleep_bias_reduce_five,
   input wire i_sleep_refbuf_offset_cancel_on,
   // full power configuration
   input wire i_fp_current_adc_on,
   input wire i_fp_voltage_adc_on,
   input wire i_fp_bias_reduce_ten,
   input wire i_fp_bias_reduce_five,
   input wire i_fp_refbuf_offset_cancel_on,
   // measurement setup
   input wire [`TRIG_W-1:0] i_adc_trigger_compare,
   input wire [`LOOP_CNT_W-1:0] i_current_only_loop_count,
   input wire [`CONV_CNT_W-1:0] i_current_conv_count,
   input wire [`CONV_CNT_W-1:0] i_voltage_conv_count,
   // interrupts
   input wire [`IRQ_W-1:0] i_wake_irq_enable,
   input wire [`IRQ_W-1:0] i_irq_pending,
   // converter and analog status
   input wire i_current_conv_done,
   input wire i_voltage_conv_done,
   input wire i_blocks_stable,
   input wire i_slow_oscillator_clock,
   // converter control
   output reg o_current_adc_power,
   output reg o_voltage_adc_power,
   output reg o_current_adc_start,
   output reg o_voltage_adc_start,
   output reg o_voltage_adc_temp_mode,
   output reg o_temp_external,
   output reg o_adc_stop,
   output reg o_power_manager_owns_adc,
   // power and clock control
   output reg o_bias_reduce_ten,
   output reg o_bias_reduce_five,
   output reg o_refbuf_offset_cancel_on,
   output reg o_analog_power,
   output reg o_muxed_clock_slow,
   output reg o_cpu_clock_enable,
   output reg o_cpu_reset_n,
   output reg o_sleep_timer_clear,
   output reg o_lin_wake_detect_enable,
   // status
   output reg o_sleep_active,
   output reg o_deep_sleep,
   output reg o_command_rejected
);

localparam [6:0] ST_FULL = 7'h01;
localparam [6:0] ST_ENTER = 7'h02;
localparam [6:0] ST_IDLE = 7'h04;
localparam [6:0] ST_CUR = 7'h08;
localparam [6:0] ST_VOLT = 7'h10;
localparam [6:0] ST_TEMP = 7'h20;
localparam [6:0] ST_WAKE = 7'h40;

// sources allowed to wake for a given measurement setup
function [`IRQ_W-1:0] wake_allowed;
   input [`MEAS_W-1:0] meas;
   reg [`IRQ_W-1:0] m;
   begin
      m = {`IRQ_W{1'b0}};
      m[`IRQ_WATCHDOG] = 1'b1;
      m[`IRQ_SLEEP_TIMER] = 1'b1;
      m[`IRQ_LIN_WAKE] = 1'b1;
      case (meas)
         `MEAS_CUR: begin
            m[`IRQ_ADC_CURRENT] = 1'b1;
         end
         `MEAS_CVT_INT, `MEAS_CVT_EXT: begin
            m = {`IRQ_W{1'b1}};
            m[`IRQ_LIN_SHORT] = 1'b0;
            m[`IRQ_LIN_TXD_TIMEOUT] = 1'b0;
         end
         default: begin
            m = m;
         end
      endcase
      wake_allowed = m;
   end
endfunction

// setups that measure at discrete times
function is_discrete;
   input [`MEAS_W-1:0] meas;
   begin
      is_discrete = (meas == `MEAS_CUR) || (meas == `MEAS_CVT_INT) || (meas == `MEAS_CVT_EXT);
   end
endfunction

reg [6:0] state_q;
reg [6:0] state_d;
reg cs_meta_q;
reg cs_sync_q;
reg cs_prev_q;
reg stable_meta_q;
reg stable_sync_q;
reg armed_q;
reg deep_q;
reg [`MEAS_W-1:0] meas_q;
reg [`CONV_CNT_W-1:0] conv_q;
reg [`LOOP_CNT_W-1:0] loop_q;
reg timer_clear_q;
wire trig_fire;
wire cs_rise;
wire [`IRQ_W-1:0] irq_live;
wire wake_now;
wire wake_at_cmd;
wire cmd_go;
wire cur_last;
wire volt_last;
wire full_loop;
wire in_sleep;

assign irq_live = i_irq_pending & i_wake_irq_enable;
assign wake_now = |(irq_live & wake_allowed(meas_q));
assign wake_at_cmd = |(irq_live & wake_allowed(i_powerdown_measure_select));
// power-down only starts once chip select is released after the command byte
assign cs_rise = cs_sync_q & ~cs_prev_q;
assign cmd_go = armed_q & cs_rise;
// a configured count of zero still performs one conversion
assign cur_last = i_current_conv_done && (conv_q + 1'b1 >= i_current_conv_count);
assign volt_last = i_voltage_conv_done && (conv_q + 1'b1 >= i_voltage_conv_count);
assign full_loop = (meas_q != `MEAS_CUR) && (loop_q >= i_current_only_loop_count);
assign in_sleep = ~state_q[0] & ~state_q[6];

adc_trigger_timer u_trig (
   .i_sys_clk(i_sys_clk),
   .i_resetn(i_resetn),
   .i_clk_en(i_clk_en),
   .i_slow_clk(i_slow_oscillator_clock),
   .i_clear(timer_clear_q),
   .i_enable(in_sleep && is_discrete(meas_q)),
   .i_compare(i_adc_trigger_compare),
   .o_fire(trig_fire)
);

always @* begin
   state_d = state_q;
   case (state_q)
      ST_FULL: begin
         if (cmd_go && !wake_at_cmd) begin
            state_d = ST_ENTER;
         end
      end
      ST_ENTER: begin
         if (wake_now) begin
            state_d = ST_WAKE;
         end else begin
            state_d = ST_IDLE;
         end
      end
      ST_IDLE: begin
         if (wake_now) begin
            state_d = ST_WAKE;
         end else if (trig_fire && is_discrete(meas_q)) begin
            state_d = ST_CUR;
         end
      end
      ST_CUR: begin
         if (wake_now) begin
            state_d = ST_WAKE;
         end else if (cur_last) begin
            state_d = full_loop ? ST_VOLT : ST_IDLE;
         end
      end
      ST_VOLT: begin
         if (wake_now) begin
            state_d = ST_WAKE;
         end else if (volt_last) begin
            state_d = ST_TEMP;
         end
      end
      ST_TEMP: begin
         if (wake_now) begin
            state_d = ST_WAKE;
         end else if (i_voltage_conv_done) begin
            state_d = ST_IDLE;
         end
      end
      ST_WAKE: begin
         if (stable_sync_q) begin
            state_d = ST_FULL;
         end
      end
      default: begin
         state_d = ST_FULL;
      end
   endcase
end

always @(posedge i_sys_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      state_q <= ST_FULL;
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      stable_meta_q <= 1'b0;
      stable_sync_q <= 1'b0;
      armed_q <= 1'b0;
      deep_q <= 1'b0;
      meas_q <= `MEAS_NONE;
      conv_q <= {`CONV_CNT_W{1'b0}};
      loop_q <= {`LOOP_CNT_W{1'b0}};
      timer_clear_q <= 1'b0;
   end else if (i_clk_en) begin
      cs_meta_q <= i_chip_select_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      stable_meta_q <= i_blocks_stable;
      stable_sync_q <= stable_meta_q;
      state_q <= state_d;
      timer_clear_q <= 1'b0;
      // any other byte written to the command register disarms the request
      if (state_q == ST_FULL && i_powerdown_command_wr) begin
         armed_q <= (i_powerdown_command == `PD_COMMAND_VALUE);
      end else if (cs_rise) begin
         armed_q <= 1'b0;
      end
      if (state_q == ST_FULL && state_d == ST_ENTER) begin
         deep_q <= (i_powerdown_state_select == `PD_STATE_DEEP);
         meas_q <= i_powerdown_measure_select;
         loop_q <= {`LOOP_CNT_W{1'b0}};
         timer_clear_q <= 1'b1;
      end
      if (state_d != state_q) begin
         conv_q <= {`CONV_CNT_W{1'b0}};
      end else if ((state_q == ST_CUR && i_current_conv_done) || (state_q == ST_VOLT && i_voltage_conv_done)) begin
         conv_q <= conv_q + 1'b1;
      end
      if (state_q == ST_CUR && state_d == ST_IDLE && meas_q != `MEAS_CUR) begin
         loop_q <= loop_q + 1'b1;
      end else if (state_q == ST_TEMP && state_d == ST_IDLE) begin
         loop_q <= {`LOOP_CNT_W{1'b0}};
      end
   end
end

// registered outputs, derived from the next state so they line up with it
always @(posedge i_sys_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      o_current_adc_power <= 1'b0;
      o_voltage_adc_power <= 1'b0;
      o_current_adc_start <= 1'b0;
      o_voltage_adc_start <= 1'b0;
      o_voltage_adc_temp_mode <= 1'b0;
      o_temp_external <= 1'b0;
      o_adc_stop <= 1'b0;
      o_power_manager_owns_adc <= 1'b0;
      o_bias_reduce_ten <= 1'b0;
      o_bias_reduce_five <= 1'b0;
      o_refbuf_offset_cancel_on <= 1'b1;
      o_analog_power <= 1'b1;
      o_muxed_clock_slow <= 1'b0;
      o_cpu_clock_enable <= 1'b1;
      o_cpu_reset_n <= 1'b1;
      o_sleep_timer_clear <= 1'b0;
      o_lin_wake_detect_enable <= 1'b0;
      o_sleep_active <= 1'b0;
      o_deep_sleep <= 1'b0;
      o_command_rejected <= 1'b0;
   end else if (i_clk_en) begin
      o_sleep_timer_clear <= timer_clear_q;
      o_lin_wake_detect_enable <= i_wake_irq_enable[`IRQ_LIN_WAKE];
      o_command_rejected <= (state_q == ST_FULL) && cmd_go && wake_at_cmd;
      // stop pulses on entry and on an abort of a running conversion
      o_adc_stop <= (state_q == ST_FULL && state_d == ST_ENTER) ||
                    ((state_q == ST_CUR || state_q == ST_VOLT || state_q == ST_TEMP) && state_d == ST_WAKE);
      o_current_adc_start <= (state_q != ST_CUR) && (state_d == ST_CUR);
      o_voltage_adc_start <= ((state_q != ST_VOLT) && (state_d == ST_VOLT)) ||
                             ((state_q != ST_TEMP) && (state_d == ST_TEMP));
      o_voltage_adc_temp_mode <= (state_d == ST_TEMP);
      o_temp_external <= (meas_q == `MEAS_CVT_EXT);
      case (state_d)
         ST_FULL: begin
            o_current_adc_power <= i_fp_current_adc_on;
            o_voltage_adc_power <= i_fp_voltage_adc_on;
            o_power_manager_owns_adc <= 1'b0;
            o_bias_reduce_ten <= i_fp_bias_reduce_ten;
            o_bias_reduce_five <= i_fp_bias_reduce_five;
            o_refbuf_offset_cancel_on <= i_fp_refbuf_offset_cancel_on;
            o_analog_power <= 1'b1;
            o_muxed_clock_slow <= 1'b0;
            o_cpu_clock_enable <= 1'b1;
            o_cpu_reset_n <= 1'b1;
            o_sleep_active <= 1'b0;
            o_deep_sleep <= 1'b0;
         end
         ST_WAKE: begin
            // full power settings come back first, processor waits for stability
            o_current_adc_power <= i_fp_current_adc_on;
            o_voltage_adc_power <= i_fp_voltage_adc_on;
            o_power_manager_owns_adc <= 1'b0;
            o_bias_reduce_ten <= i_fp_bias_reduce_ten;
            o_bias_reduce_five <= i_fp_bias_reduce_five;
            o_refbuf_offset_cancel_on <= i_fp_refbuf_offset_cancel_on;
            o_analog_power <= 1'b1;
            o_muxed_clock_slow <= 1'b0;
            o_cpu_clock_enable <= 1'b0;
            o_cpu_reset_n <= ~deep_q;
            o_sleep_active <= 1'b0;
            o_deep_sleep <= deep_q;
         end
         default: begin
            // converters powered only while their phase runs
            o_current_adc_power <= (state_d == ST_CUR);
            o_voltage_adc_power <= (state_d == ST_VOLT) || (state_d == ST_TEMP);
            o_power_manager_owns_adc <= 1'b1;
            o_bias_reduce_ten <= i_sleep_bias_reduce_ten;
            o_bias_reduce_five <= i_sleep_bias_reduce_five;
            o_refbuf_offset_cancel_on <= i_sleep_refbuf_offset_cancel_on;
            o_analog_power <= (state_d == ST_CUR) || (state_d == ST_VOLT) || (state_d == ST_TEMP);
            o_muxed_clock_slow <= 1'b1;
            o_cpu_clock_enable <= 1'b0;
            o_cpu_reset_n <= (state_d == ST_ENTER) ? ~(i_powerdown_state_select == `PD_STATE_DEEP) : ~deep_q;
            o_sleep_active <= 1'b1;
            o_deep_sleep <= (state_d == ST_ENTER) ? (i_powerdown_state_select == `PD_STATE_DEEP) : deep_q;
         end
      endcase
   end
end

endmodule

// [pkg/sleep_seq_consts.vh]
// constants for the sleep measurement sequencer
`ifndef SLEEP_SEQ_CONSTS_VH
`define SLEEP_SEQ_CONSTS_VH

`define PD_COMMAND_VALUE 8'hA9
`define CMD_W 8

`define PD_STATE_W 2
`define PD_STATE_DEEP 2'h2

`define MEAS_W 3
`define MEAS_NONE 3'h0
`define MEAS_CUR 3'h1
`define MEAS_CVT_INT 3'h2
`define MEAS_CVT_EXT 3'h3

`define IRQ_W 8
`define IRQ_WATCHDOG 0
`define IRQ_SLEEP_TIMER 1
`define IRQ_ADC_CURRENT 2
`define IRQ_ADC_VOLTAGE 3
`define IRQ_LIN_WAKE 4
`define IRQ_LIN_SHORT 5
`define IRQ_LIN_TXD_TIMEOUT 6
`define IRQ_ADC_TEMP 7

`define CONV_CNT_W 4
`define LOOP_CNT_W 8
`define TRIG_W 16

`endif

// [core/adc_trigger_timer.v]
// adc trigger timer counting edges of the slow oscillator clock
`timescale 1ns/10ps
`include "sleep_seq_consts.vh"
module adc_trigger_timer (
   // clock and reset
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_clk_en,
   // slow oscillator clock pin
   input wire i_slow_clk,
   // control
   input wire i_clear,
   input wire i_enable,
   input wire [`TRIG_W-1:0] i_compare,
   // trigger pulse
   output reg o_fire
);

reg slow_meta_q;
reg slow_sync_q;
reg slow_prev_q;
reg [`TRIG_W-1:0] count_q;
wire slow_rise;

assign slow_rise = slow_sync_q & ~slow_prev_q;

always @(posedge i_sys_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      slow_meta_q <= 1'b0;
      slow_sync_q <= 1'b0;
      slow_prev_q <= 1'b0;
      count_q <= {`TRIG_W{1'b0}};
      o_fire <= 1'b0;
   end else if (i_clk_en) begin
      slow_meta_q <= i_slow_clk;
      slow_sync_q <= slow_meta_q;
      slow_prev_q <= slow_sync_q;
      o_fire <= 1'b0;
      if (i_clear || !i_enable) begin
         count_q <= {`TRIG_W{1'b0}};
      end else if (slow_rise) begin
         // a compare of zero behaves as one slow period so the loop never spins
         if (count_q + 1'b1 >= i_compare) begin
            count_q <= {`TRIG_W{1'b0}};
            o_fire <= 1'b1;
         end else begin
            count_q <= count_q + 1'b1;
         end
      end
   end
end

endmodule

// [tb/sleep_seq_checker_asserts.sv]
// port-level assertions for the sleep measurement sequencer
`timescale 1ns/10ps
`include "sleep_seq_consts.vh"
module sleep_seq_checker (
   // clock and reset
   input wire i_sys_clk,
   input wire i_resetn,
   // configuration and interrupts
   input wire [`PD_STATE_W-1:0] i_powerdown_state_select,
   input wire [`MEAS_W-1:0] i_powerdown_measure_select,
   input wire i_fp_bias_reduce_ten,
   input wire [`IRQ_W-1:0] i_wake_irq_enable,
   input wire [`IRQ_W-1:0] i_irq_pending,
   // watched outputs
   input wire o_current_adc_power,
   input wire o_voltage_adc_power,
   input wire o_current_adc_start,
   input wire o_voltage_adc_start,
   input wire o_voltage_adc_temp_mode,
   input wire o_adc_stop,
   input wire o_power_manager_owns_adc,
   input wire o_bias_reduce_ten,
   input wire o_analog_power,
   input wire o_muxed_clock_slow,
   input wire o_cpu_clock_enable,
   input wire o_cpu_reset_n,
   input wire o_sleep_timer_clear,
   input wire o_lin_wake_detect_enable,
   input wire o_sleep_active,
   input wire o_deep_sleep,
   input wire o_command_rejected
);
   // watchdog, sleep timer and LIN wake may end every setup
   wire common_wake = |(i_wake_irq_enable & i_irq_pending & 8'h13);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   sleep_clock_a: assert property (
      o_sleep_active |-> o_muxed_clock_slow && o_power_manager_owns_adc && !o_cpu_clock_enable)
      else $error("sleep without slow clock or handover");
   entry_pulses_a: assert property (
      $rose(o_sleep_active) |-> o_adc_stop ##1 o_sleep_timer_clear) else $error("entry pulses missing");
   deep_select_a: assert property (
      $rose(o_sleep_active) |-> o_deep_sleep == (i_powerdown_state_select == `PD_STATE_DEEP))
      else $error("sleep depth differs from select");
   none_dark_a: assert property (
      o_sleep_active && $past(o_sleep_active) && i_powerdown_measure_select == `MEAS_NONE
      |-> !o_current_adc_power && !o_voltage_adc_power && !o_analog_power) else $error("analog powered");
   cur_only_a: assert property (
      o_sleep_active && $past(o_sleep_active) && i_powerdown_measure_select == `MEAS_CUR
      |-> !o_voltage_adc_power) else $error("voltage converter powered");
   start_power_a: assert property (
      o_current_adc_start |-> o_current_adc_power && o_sleep_active) else $error("start without power");
   temp_start_a: assert property (
      $rose(o_voltage_adc_temp_mode) |-> o_voltage_adc_start && o_voltage_adc_power)
      else $error("temperature phase without start");
   deep_reset_a: assert property (
      o_sleep_active && o_deep_sleep |-> !o_cpu_reset_n) else $error("processor out of reset in deep sleep");
   wake_exit_a: assert property (
      o_sleep_active && common_wake |-> ##[1:8] !o_sleep_active) else $error("enabled wake ignored");
   lin_detect_a: assert property (
      $past(i_resetn) |-> o_lin_wake_detect_enable == $past(i_wake_irq_enable[`IRQ_LIN_WAKE]))
      else $error("lin detector enable wrong");
   fp_restore_a: assert property (
      $past(i_resetn) && !o_sleep_active && !$past(o_sleep_active)
      |-> o_bias_reduce_ten == $past(i_fp_bias_reduce_ten)) else $error("full power bias not applied");
   deep_entry_c: cover property ($rose(o_sleep_active) && o_deep_sleep);
   temp_phase_c: cover property ($rose(o_voltage_adc_temp_mode));
   reject_c: cover property (o_command_rejected);
endmodule
bind sleep_measurement_sequencer sleep_seq_checker i_chk (.*);

// [tb/host_port_model.sv]
// host model issuing command writes and chip select on the register port
`timescale 1ns/10ps
`include "sleep_seq_consts.vh"
module host_port_model (
   // clock
   input wire i_sys_clk,
   // register port
   output logic o_command_wr,
   output logic [`CMD_W-1:0] o_command,
   output logic o_chip_select_n
);
   initial begin
      o_command_wr = 1'b0;
      o_command = 8'h00;
      o_chip_select_n = 1'b1;
   end
   task automatic write_command(input logic [`CMD_W-1:0] value, input logic deselect);
      @(negedge i_sys_clk);
      o_chip_select_n = 1'b0;
      @(negedge i_sys_clk);
      o_command_wr = 1'b1;
      o_command = value;
      @(negedge i_sys_clk);
      o_command_wr = 1'b0;
      // nothing holds the data lines once the write is over
      o_command = ~value;
      repeat (2) @(negedge i_sys_clk);
      if (deselect) o_chip_select_n = 1'b1;
   endtask
endmodule

// [tb/sleep_measurement_sequencer_tb_top.sv]
// self-checking bench for the sleep measurement sequencer
`timescale 1ns/10ps
`include "sleep_seq_consts.vh"
module sleep_measurement_sequencer_tb_top;
   logic i_sys_clk, i_resetn, i_clk_en, i_slow_oscillator_clock, i_blocks_stable;
   logic i_current_conv_done, i_voltage_conv_done;
   logic i_sleep_bias_reduce_ten, i_sleep_bias_reduce_five, i_sleep_refbuf_offset_cancel_on;
   logic i_fp_current_adc_on, i_fp_voltage_adc_on, i_fp_bias_reduce_ten;
   logic i_fp_bias_reduce_five, i_fp_refbuf_offset_cancel_on;
   logic [`PD_STATE_W-1:0] i_powerdown_state_select;
   logic [`MEAS_W-1:0] i_powerdown_measure_select;
   logic [`TRIG_W-1:0] i_adc_trigger_compare;
   logic [`LOOP_CNT_W-1:0] i_current_only_loop_count;
   logic [`CONV_CNT_W-1:0] i_current_conv_count, i_voltage_conv_count;
   logic [`IRQ_W-1:0] i_wake_irq_enable, i_irq_pending;
   wire i_powerdown_command_wr, i_chip_select_n;
   wire [`CMD_W-1:0] i_powerdown_command;
   wire o_current_adc_power, o_voltage_adc_power, o_current_adc_start, o_voltage_adc_start;
   wire o_voltage_adc_temp_mode, o_temp_external, o_adc_stop, o_power_manager_owns_adc;
   wire o_bias_reduce_ten, o_bias_reduce_five, o_refbuf_offset_cancel_on, o_analog_power;
   wire o_muxed_clock_slow, o_cpu_clock_enable, o_cpu_reset_n, o_sleep_timer_clear;
   wire o_lin_wake_detect_enable, o_sleep_active, o_deep_sleep, o_command_rejected;
   wire [4:0] mon = {o_cpu_clock_enable, o_command_rejected, o_sleep_active, o_voltage_adc_start, o_current_adc_start};
   int miscompares = 0;
   int comparisons = 0;
   int stops = 0;
   int s0;
   sleep_measurement_sequencer i_dut (.*);
   host_port_model host (
      .i_sys_clk(i_sys_clk),
      .o_command_wr(i_powerdown_command_wr),
      .o_command(i_powerdown_command),
      .o_chip_select_n(i_chip_select_n)
   );
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   // free-running slow oscillator, deliberately off phase from the system clock
   initial begin
      i_slow_oscillator_clock = 1'b0;
      #7.3;
      forever #62.5 i_slow_oscillator_clock = ~i_slow_oscillator_clock;
   end
   always @(posedge i_sys_clk) if (o_adc_stop === 1'b1) stops <= stops + 1;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wait_mon(input int k, input logic level);
      int n;
      n = 0;
      while (mon[k] !== level && n < 600) begin
         @(negedge i_sys_clk);
         n++;
      end
      check(mon[k], level);
   endtask
   task automatic conv_done(input logic volt, input int count);
      repeat (count) begin
         repeat (3) @(negedge i_sys_clk);
         i_voltage_conv_done = volt;
         i_current_conv_done = ~volt;
         @(negedge i_sys_clk);
         i_voltage_conv_done = 1'b0;
         i_current_conv_done = 1'b0;
      end
   endtask
   task automatic setup(input logic [1:0] st, input logic [2:0] meas, input logic [7:0] ena, input logic [7:0] loops);
      i_powerdown_state_select = st;
      i_powerdown_measure_select = meas;
      i_wake_irq_enable = ena;
      i_current_only_loop_count = loops;
      i_irq_pending = 8'h00;
   endtask
   task automatic enter;
      host.write_command(8'hA9, 1'b1);
      wait_mon(2, 1'b1);
      i_blocks_stable = 1'b0;
      repeat (3) @(negedge i_sys_clk);
      check({o_bias_reduce_ten, o_bias_reduce_five, o_refbuf_offset_cancel_on},
         {i_sleep_bias_reduce_ten, i_sleep_bias_reduce_five, i_sleep_refbuf_offset_cancel_on});
      check(o_current_adc_power, 1'b0);
   endtask
   task automatic wake(input int src, input logic deep);
      i_irq_pending[src] = 1'b1;
      wait_mon(2, 1'b0);
      repeat (4) @(negedge i_sys_clk);
      check({o_cpu_clock_enable, o_cpu_reset_n}, {1'b0, ~deep});
      i_irq_pending = 8'h00;
      i_blocks_stable = 1'b1;
      wait_mon(4, 1'b1);
      check({o_cpu_reset_n, o_current_adc_power, o_voltage_adc_power, o_bias_reduce_ten, o_bias_reduce_five,
         o_refbuf_offset_cancel_on}, {1'b1, i_fp_current_adc_on, i_fp_voltage_adc_on, i_fp_bias_reduce_ten,
         i_fp_bias_reduce_five, i_fp_refbuf_offset_cancel_on});
   endtask
   task automatic test_no_measure;
      setup(2'h1, `MEAS_NONE, 8'h05, 8'h00);
      enter();
      check({o_deep_sleep, o_analog_power, o_lin_wake_detect_enable}, 3'h0);
      i_irq_pending[`IRQ_ADC_CURRENT] = 1'b1;
      repeat (30) @(negedge i_sys_clk);
      check(o_sleep_active, 1'b1);
      // a frozen clock enable must hold off the wake; kept short so the wake bound still holds
      i_clk_en = 1'b0;
      i_irq_pending[`IRQ_WATCHDOG] = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      check(o_sleep_active, 1'b1);
      i_clk_en = 1'b1;
      wake(`IRQ_WATCHDOG, 1'b0);
      $display("test no_measure done");
   endtask
   task automatic test_deep;
      i_fp_current_adc_on = 1'b0;
      i_fp_bias_reduce_ten = 1'b1;
      setup(2'h2, `MEAS_NONE, 8'h10, 8'h00);
      enter();
      check({o_deep_sleep, o_cpu_reset_n, o_lin_wake_detect_enable}, 3'h5);
      wake(`IRQ_LIN_WAKE, 1'b1);
      $display("test deep done");
   endtask
   task automatic test_reject;
      setup(2'h0, `MEAS_NONE, 8'h10, 8'h00);
      host.write_command(8'hA9, 1'b0);
      repeat (20) @(negedge i_sys_clk);
      check(o_sleep_active, 1'b0);
      host.write_command(8'h55, 1'b1);
      repeat (20) @(negedge i_sys_clk);
      check(o_sleep_active, 1'b0);
      i_irq_pending[`IRQ_LIN_WAKE] = 1'b1;
      host.write_command(8'hA9, 1'b1);
      wait_mon(3, 1'b1);
      repeat (10) @(negedge i_sys_clk);
      check(o_sleep_active, 1'b0);
      i_irq_pending = 8'h00;
      $display("test reject done");
   endtask
   task automatic test_current;
      i_fp_voltage_adc_on = 1'b1;
      setup(2'h1, `MEAS_CUR, 8'h04, 8'h00);
      s0 = stops;
      enter();
      repeat (2) begin
         wait_mon(0, 1'b1);
         conv_done(1'b0, 1);
         check(o_current_adc_power, 1'b1);
         conv_done(1'b0, 1);
         repeat (3) @(negedge i_sys_clk);
         check({o_current_adc_power, o_voltage_adc_power}, 2'h0);
      end
      wait_mon(0, 1'b1);
      wake(`IRQ_ADC_CURRENT, 1'b0);
      check(stops - s0, 2);
      $display("test current done");
   endtask
   task automatic test_full_ext;
      setup(2'h0, `MEAS_CVT_EXT, 8'h22, 8'h01);
      enter();
      i_irq_pending[`IRQ_LIN_SHORT] = 1'b1;
      for (int loop = 0; loop < 3; loop++) begin
         wait_mon(0, 1'b1);
         conv_done(1'b0, 2);
         if (loop == 1) begin
            wait_mon(1, 1'b1);
            conv_done(1'b1, 1);
            check(o_voltage_adc_temp_mode, 1'b0);
            conv_done(1'b1, 1);
            wait_mon(1, 1'b1);
            check({o_voltage_adc_temp_mode, o_temp_external}, 2'h3);
            conv_done(1'b1, 1);
         end
         repeat (3) @(negedge i_sys_clk);
         check({o_current_adc_power, o_voltage_adc_power}, 2'h0);
      end
      check(o_sleep_active, 1'b1);
      wake(`IRQ_SLEEP_TIMER, 1'b0);
      $display("test full_ext done");
   endtask
   task automatic test_full_abort;
      setup(2'h2, `MEAS_CVT_INT, 8'h02, 8'h00);
      s0 = stops;
      enter();
      wait_mon(0, 1'b1);
      conv_done(1'b0, 2);
      wait_mon(1, 1'b1);
      check({o_voltage_adc_temp_mode, o_temp_external}, 2'h0);
      wake(`IRQ_SLEEP_TIMER, 1'b1);
      check(stops - s0, 2);
      $display("test full_abort done");
   endtask
   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
   initial begin
      i_resetn = 1'b0;
      i_clk_en = 1'b1;
      i_blocks_stable = 1'b1;
      i_current_conv_done = 1'b0;
      i_voltage_conv_done = 1'b0;
      i_sleep_bias_reduce_ten = 1'b1;
      i_sleep_bias_reduce_five = 1'b1;
      i_sleep_refbuf_offset_cancel_on = 1'b1;
      i_fp_current_adc_on = 1'b1;
      i_fp_voltage_adc_on = 1'b0;
      i_fp_bias_reduce_ten = 1'b0;
      i_fp_bias_reduce_five = 1'b0;
      i_fp_refbuf_offset_cancel_on = 1'b0;
      i_adc_trigger_compare = 16'h0004;
      i_current_conv_count = 4'h2;
      i_voltage_conv_count = 4'h2;
      setup(2'h0, `MEAS_NONE, 8'h00, 8'h00);
      repeat (12) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_resetn = 1'b1;
      repeat (5) @(negedge i_sys_clk);
      test_no_measure();
      test_deep();
      test_reject();
      test_current();
      test_full_ext();
      test_full_abort();
      give_verdict();
   end
endmodule
